//--- design/sync_holdover_refin_config.sv
// Configuration bank for sync, lock/holdover/status pins, holdover entry and ref inputs.
// Assumes the serial pins come from outside the mclk domain; lock inputs are on mclk.
`timescale 1ns/100ps
`default_nettype none

// Contract
// R01: Power-on reset loads every field default
// R02: Bits 25:20 exclude outputs from sync
// R03: Bits 19:18 choose sync pin output source
// R04: Bit 17 qualifies sync with clock output
// R05: Bit 16 sets sync input polarity
// R06: Manual mode: output writes start no sync
// R07: Bits 31:27 choose lock pin source
// R08: Bit 23 holds sync until loop2 lock
// R09: Bit 22 holds sync until loop1 lock
// R10: Bit 8 makes DAC track loop1 voltage
// R11: Bits 7:6 control holdover entry on loss
// R12: Bits 26:24 set holdover pin kind
// R13: Bits 18:16 set status-0 pin kind
// R14: Bits 22:20 choose status-1 pin source
// R15: Bits 14:12 choose status-0 pin source
// R16: Bit 15 ignores loop1 lock drop
// R17: Bits 11:9 choose reference selection mode
// R18: Bit 8 inverts status selection inputs
// R19: Bits 7:5 mark reference inputs usable
// R20: Bits 31:30 set loss inactivity time
// R21: Bit 28 enables loss-of-signal detection
// R22: Register zero bit 17 restores defaults
// R23: Undefined bits read zero, ignore writes
module sync_holdover_refin_config (
    input wire logic mclk,
    input wire logic reset,
    input wire logic spi_clk, // Serial clock pin
    input wire logic spi_data, // Serial data pin, MSB first
    input wire logic spi_latch, // Latch pin, frame taken on rising edge
    output logic spi_readout, // Readback data pin
    input wire logic loop1_lock, // First loop digital lock detect
    input wire logic loop2_lock, // Second loop digital lock detect
    input wire logic sync_pin_in, // Sync pin level as input
    output logic [5:0] sync_exclude, // Per-output sync exclusion
    output logic [1:0] sync_pin_out_source,
    output logic sync_output_qualify,
    output logic sync_pin_polarity,
    output logic sync_request, // Sync pin active and sync enabled
    output logic sync_auto_start, // Pulse: sync started by output write
    output logic sync_hold, // Outputs held in sync state
    output logic [4:0] lock_pin_source,
    output logic [2:0] lock_pin_kind,
    output logic dac_track_on,
    output logic [1:0] holdover_mode,
    output logic holdover_enter, // Pulse: holdover entry on lock drop
    output logic [2:0] holdover_pin_kind,
    output logic [2:0] status1_pin_source,
    output logic [2:0] status0_pin_kind,
    output logic [2:0] status0_pin_source,
    output logic loop1_lock_drop_ignore,
    output logic [2:0] reference_choice_mode,
    output logic status_input_invert,
    output logic [2:0] ref_input_usable, // Bit n marks input n usable
    output logic [1:0] inactivity_loss_time,
    output logic signal_loss_detect_on
);

    logic [2:0] clk_sy_r; // Three-stage synchroniser, serial clock
    logic [2:0] dat_sy_r; // Three-stage synchroniser, serial data
    logic [2:0] lat_sy_r; // Three-stage synchroniser, latch
    logic [2:0] syn_sy_r; // Three-stage synchroniser, sync pin
    logic clk_f_r; // Filtered serial clock
    logic dat_f_r; // Filtered serial data
    logic lat_f_r; // Filtered latch
    logic syn_f_r; // Filtered sync pin
    logic clk_rise; // Serial clock rising edge
    logic lat_rise; // Latch rising edge
    logic [31:0] shift_r; // Incoming frame
    logic [31:0] rd_r; // Outgoing readback word
    logic [31:0] sync_mode_config_r;
    logic [31:0] lock_pin_and_holdover_config_r;
    logic [31:0] holdover_pin_and_ref_select_r;
    logic [31:0] ref_loss_detect_config_r;
    logic [4:0] readback_sel_r; // Register chosen for readback
    logic [4:0] frame_addr; // Address field of the frame
    logic soft_reset; // Frame requests device reset
    logic [31:0] rd_sel; // Selected register for readback
    logic sync_auto_start_r;
    logic holdover_enter_r;
    logic loop1_lock_d_r; // Previous loop1 lock level

    // Synchronisers: first stage feeds only the second
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            clk_sy_r <= 3'h0;
            dat_sy_r <= 3'h0;
            lat_sy_r <= 3'h0;
            syn_sy_r <= 3'h7;
        end else begin
            clk_sy_r <= {clk_sy_r[1:0], spi_clk};
            dat_sy_r <= {dat_sy_r[1:0], spi_data};
            lat_sy_r <= {lat_sy_r[1:0], spi_latch};
            syn_sy_r <= {syn_sy_r[1:0], sync_pin_in};
        end
    end

    // Filtered levels change once stages two and three agree
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            clk_f_r <= 1'b0;
            dat_f_r <= 1'b0;
            lat_f_r <= 1'b0;
            syn_f_r <= 1'b1;
        end else begin
            if (clk_sy_r[1] == clk_sy_r[2]) begin
                clk_f_r <= clk_sy_r[2];
            end
            if (dat_sy_r[1] == dat_sy_r[2]) begin
                dat_f_r <= dat_sy_r[2];
            end
            if (lat_sy_r[1] == lat_sy_r[2]) begin
                lat_f_r <= lat_sy_r[2];
            end
            if (syn_sy_r[1] == syn_sy_r[2]) begin
                syn_f_r <= syn_sy_r[2];
            end
        end
    end

    // Edge detection on the filtered levels
    assign clk_rise = (clk_sy_r[1] == clk_sy_r[2]) && clk_sy_r[2] && !clk_f_r;
    assign lat_rise = (lat_sy_r[1] == lat_sy_r[2]) && lat_sy_r[2] && !lat_f_r;
    assign frame_addr =
        shift_r[sync_holdover_refin_pkg::ADDR_LSB +: sync_holdover_refin_pkg::ADDR_W];
    assign soft_reset = lat_rise && (frame_addr == sync_holdover_refin_pkg::ADDR_DEVICE_RESET)
        && shift_r[sync_holdover_refin_pkg::SOFT_RESET_BIT];

    // Frame shift register, data sampled at serial clock rise
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            shift_r <= 32'h0000_0000;
        end else if (clk_rise) begin
            shift_r <= {shift_r[30:0], dat_f_r};
        end
    end

    // Register bank writes; reset, pin or soft, loads defaults
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            sync_mode_config_r <= sync_holdover_refin_pkg::SYNC_MODE_RST; // see R01
            lock_pin_and_holdover_config_r <= sync_holdover_refin_pkg::LOCK_HOLD_RST;
            holdover_pin_and_ref_select_r <= sync_holdover_refin_pkg::HOLD_REFSEL_RST;
            ref_loss_detect_config_r <= sync_holdover_refin_pkg::LOSS_DET_RST;
            readback_sel_r <= sync_holdover_refin_pkg::READBACK_SEL_RST;
        end else if (soft_reset) begin
            // Device reset frame restores every default, see R22
            sync_mode_config_r <= sync_holdover_refin_pkg::SYNC_MODE_RST;
            lock_pin_and_holdover_config_r <= sync_holdover_refin_pkg::LOCK_HOLD_RST;
            holdover_pin_and_ref_select_r <= sync_holdover_refin_pkg::HOLD_REFSEL_RST;
            ref_loss_detect_config_r <= sync_holdover_refin_pkg::LOSS_DET_RST;
            readback_sel_r <= sync_holdover_refin_pkg::READBACK_SEL_RST;
        end else if (lat_rise) begin
            case (frame_addr)
                // Masked writes keep undefined bits at zero, see R23
                sync_holdover_refin_pkg::ADDR_SYNC_MODE: begin
                    sync_mode_config_r <= shift_r & sync_holdover_refin_pkg::SYNC_MODE_MASK;
                end
                sync_holdover_refin_pkg::ADDR_LOCK_HOLD: begin
                    lock_pin_and_holdover_config_r <=
                        shift_r & sync_holdover_refin_pkg::LOCK_HOLD_MASK;
                end
                sync_holdover_refin_pkg::ADDR_HOLD_REFSEL: begin
                    holdover_pin_and_ref_select_r <=
                        shift_r & sync_holdover_refin_pkg::HOLD_REFSEL_MASK;
                end
                sync_holdover_refin_pkg::ADDR_LOSS_DET: begin
                    ref_loss_detect_config_r <= shift_r & sync_holdover_refin_pkg::LOSS_DET_MASK;
                end
                sync_holdover_refin_pkg::ADDR_READBACK_SEL: begin
                    readback_sel_r <= shift_r[sync_holdover_refin_pkg::READBACK_LSB +: 5];
                end
                default: begin
                    // Other addresses belong to other banks
                end
            endcase
        end
    end

    // Readback source selection
    always_comb begin
        case (readback_sel_r)
            sync_holdover_refin_pkg::ADDR_SYNC_MODE: rd_sel = sync_mode_config_r;
            sync_holdover_refin_pkg::ADDR_LOCK_HOLD: rd_sel = lock_pin_and_holdover_config_r;
            sync_holdover_refin_pkg::ADDR_HOLD_REFSEL: rd_sel = holdover_pin_and_ref_select_r;
            sync_holdover_refin_pkg::ADDR_LOSS_DET: rd_sel = ref_loss_detect_config_r;
            default: rd_sel = 32'h0000_0000;
        endcase
    end

    // Readback word loads at latch and shifts out MSB first on clock rise
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rd_r <= 32'h0000_0000;
        end else if (lat_rise) begin
            rd_r <= rd_sel;
        end else if (clk_rise) begin
            rd_r <= {rd_r[30:0], 1'b0};
        end
    end
    assign spi_readout = rd_r[31];

    // Sync start from output-register writes only in automatic mode
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            sync_auto_start_r <= 1'b0;
        end else begin
            sync_auto_start_r <= lat_rise && !soft_reset
                && (frame_addr <= sync_holdover_refin_pkg::ADDR_LAST_OUT_REG)
                && sync_mode_config_r[sync_holdover_refin_pkg::SYNC_AUTO_BIT]; // see R06
        end
    end
    assign sync_auto_start = sync_auto_start_r;

    // Holdover entry on loop1 lock falling edge
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            loop1_lock_d_r <= 1'b0;
            holdover_enter_r <= 1'b0;
        end else begin
            loop1_lock_d_r <= loop1_lock;
            holdover_enter_r <= loop1_lock_d_r && !loop1_lock
                && !loop1_lock_drop_ignore // see R16
                && (holdover_mode == sync_holdover_refin_pkg::HOLD_ON_LOSS); // see R11
        end
    end
    assign holdover_enter = holdover_enter_r;

    // Field outputs from the bank
    assign sync_exclude = sync_mode_config_r[sync_holdover_refin_pkg::SYNC_EXCL_LSB +: 6]; // see R02
    assign sync_pin_out_source =
        sync_mode_config_r[sync_holdover_refin_pkg::SYNC_OUT_SRC_LSB +: 2]; // see R03
    assign sync_output_qualify =
        sync_mode_config_r[sync_holdover_refin_pkg::SYNC_OUTPUT_QUALIFY_BIT]; // see R04
    assign sync_pin_polarity = sync_mode_config_r[sync_holdover_refin_pkg::SYNC_POL_BIT];
    // Polarity one means the sync pin is active low, see R05
    assign sync_request = sync_mode_config_r[sync_holdover_refin_pkg::SYNC_ENABLE_BIT]
        && (syn_f_r != sync_pin_polarity);
    // Hold outputs in sync until the selected loops lock, see R08 and R09
    assign sync_hold =
        (lock_pin_and_holdover_config_r[sync_holdover_refin_pkg::HOLD_LOOP2_BIT] && !loop2_lock)
        || (lock_pin_and_holdover_config_r[sync_holdover_refin_pkg::HOLD_LOOP1_BIT] && !loop1_lock);
    assign lock_pin_source =
        lock_pin_and_holdover_config_r[sync_holdover_refin_pkg::LOCK_SRC_LSB +: 5]; // see R07
    assign lock_pin_kind = lock_pin_and_holdover_config_r[sync_holdover_refin_pkg::LOCK_KIND_LSB +: 3];
    assign dac_track_on = lock_pin_and_holdover_config_r[sync_holdover_refin_pkg::TRACK_BIT]; // see R10
    assign holdover_mode = lock_pin_and_holdover_config_r[sync_holdover_refin_pkg::HOLD_MODE_LSB +: 2];
    assign holdover_pin_kind =
        holdover_pin_and_ref_select_r[sync_holdover_refin_pkg::HOLD_PIN_KIND_LSB +: 3]; // see R12
    assign status1_pin_source =
        holdover_pin_and_ref_select_r[sync_holdover_refin_pkg::STAT1_SRC_LSB +: 3]; // see R14
    assign status0_pin_kind =
        holdover_pin_and_ref_select_r[sync_holdover_refin_pkg::STAT0_KIND_LSB +: 3]; // see R13
    assign status0_pin_source =
        holdover_pin_and_ref_select_r[sync_holdover_refin_pkg::STAT0_SRC_LSB +: 3]; // see R15
    assign loop1_lock_drop_ignore =
        holdover_pin_and_ref_select_r[sync_holdover_refin_pkg::DROP_IGNORE_BIT];
    assign reference_choice_mode =
        holdover_pin_and_ref_select_r[sync_holdover_refin_pkg::REF_MODE_LSB +: 3]; // see R17
    assign status_input_invert =
        holdover_pin_and_ref_select_r[sync_holdover_refin_pkg::STAT_INV_BIT]; // see R18
    assign ref_input_usable =
        holdover_pin_and_ref_select_r[sync_holdover_refin_pkg::REF_USABLE_LSB +: 3]; // see R19
    assign inactivity_loss_time =
        ref_loss_detect_config_r[sync_holdover_refin_pkg::LOSS_TIME_LSB +: 2]; // see R20
    assign signal_loss_detect_on =
        ref_loss_detect_config_r[sync_holdover_refin_pkg::LOSS_ON_BIT]; // see R21

    // Defaults present on the first cycle after reset release
    property p_reset_defaults;
        @(posedge mclk) $fell(reset) |->
            sync_exclude == 6'h18 && sync_pin_out_source == 2'h0 && lock_pin_source == 5'h03
            && holdover_mode == 2'h2 && reference_choice_mode == 3'h3
            && ref_input_usable == 3'h7 && signal_loss_detect_on && sync_pin_polarity;
    endproperty
    a_reset_defaults: assert property (p_reset_defaults) else $error("defaults not loaded"); // see R01

    // Device reset frame restores defaults on the next cycle
    property p_soft_reset;
        @(posedge mclk) disable iff (reset) soft_reset |=>
            holdover_pin_kind == 3'h3 && status0_pin_kind == 3'h2 && dac_track_on
            && !sync_output_qualify && inactivity_loss_time == 2'h0 && lock_pin_kind == 3'h3;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset missed"); // see R22

    // Manual mode never starts a sync
    property p_manual_no_sync;
        @(posedge mclk) disable iff (reset)
            !$past(sync_mode_config_r[sync_holdover_refin_pkg::SYNC_AUTO_BIT]) |-> !sync_auto_start;
    endproperty
    a_manual_no_sync: assert property (p_manual_no_sync) else $error("sync in manual"); // see R06

    // Ignored lock drop never enters holdover
    property p_drop_ignored;
        @(posedge mclk) disable iff (reset)
            $past(loop1_lock_drop_ignore) |-> !holdover_enter;
    endproperty
    a_drop_ignored: assert property (p_drop_ignored) else $error("ignored drop acted"); // see R16

    // Lock drop in holdover mode two enters holdover next cycle
    property p_hold_entry;
        @(posedge mclk) disable iff (reset)
            $fell(loop1_lock) && !loop1_lock_drop_ignore && holdover_mode == 2'h2
            |=> holdover_enter ##1 !holdover_enter;
    endproperty
    a_hold_entry: assert property (p_hold_entry) else $error("holdover not entered"); // see R11

    // Undefined bits stay zero
    property p_reserved_zero;
        @(posedge mclk) disable iff (reset)
            (sync_mode_config_r & ~sync_holdover_refin_pkg::SYNC_MODE_MASK) == 32'h0
            && (lock_pin_and_holdover_config_r & ~sync_holdover_refin_pkg::LOCK_HOLD_MASK) == 32'h0
            && (holdover_pin_and_ref_select_r & ~sync_holdover_refin_pkg::HOLD_REFSEL_MASK) == 32'h0
            && (ref_loss_detect_config_r & ~sync_holdover_refin_pkg::LOSS_DET_MASK) == 32'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set"); // see R23

    // Loop2 hold forces sync state while loop2 unlocked
    property p_hold_loop2;
        @(posedge mclk) disable iff (reset)
            lock_pin_and_holdover_config_r[sync_holdover_refin_pkg::HOLD_LOOP2_BIT]
            && !loop2_lock |-> sync_hold;
    endproperty
    a_hold_loop2: assert property (p_hold_loop2) else $error("loop2 hold missing"); // see R08

    // Loop1 hold forces sync state while loop1 unlocked
    property p_hold_loop1;
        @(posedge mclk) disable iff (reset)
            lock_pin_and_holdover_config_r[sync_holdover_refin_pkg::HOLD_LOOP1_BIT]
            && !loop1_lock |-> sync_hold;
    endproperty
    a_hold_loop1: assert property (p_hold_loop1) else $error("loop1 hold missing"); // see R09

    // Written sync-mode frame shows in exclusions next cycle
    property p_excl_write;
        @(posedge mclk) disable iff (reset)
            lat_rise && frame_addr == sync_holdover_refin_pkg::ADDR_SYNC_MODE
            |=> sync_exclude == $past(shift_r[sync_holdover_refin_pkg::SYNC_EXCL_LSB +: 6]);
    endproperty
    a_excl_write: assert property (p_excl_write) else $error("exclusion not written"); // see R02

endmodule : sync_holdover_refin_config

`default_nettype wire

//--- design/sync_holdover_refin_pkg.sv
// Constants for the sync, holdover and reference-input configuration bank.
// Assumes a 32-bit serial frame with data in bits 31:5 and address in 4:0.
package sync_holdover_refin_pkg;

    // Frame layout
    localparam int FRAME_W = 32;
    localparam int ADDR_W = 5;
    localparam int ADDR_LSB = 0;

    // Register indices (address field values)
    localparam logic [4:0] ADDR_DEVICE_RESET = 5'h00;
    localparam logic [4:0] ADDR_LAST_OUT_REG = 5'h05;
    localparam logic [4:0] ADDR_SYNC_MODE = 5'h0B;
    localparam logic [4:0] ADDR_LOCK_HOLD = 5'h0C;
    localparam logic [4:0] ADDR_HOLD_REFSEL = 5'h0D;
    localparam logic [4:0] ADDR_LOSS_DET = 5'h0E;
    localparam logic [4:0] ADDR_READBACK_SEL = 5'h1F;

    // Reset values
    localparam logic [31:0] SYNC_MODE_RST = 32'h0581_1000;
    localparam logic [31:0] LOCK_HOLD_RST = 32'h1B00_0180;
    localparam logic [31:0] HOLD_REFSEL_RST = 32'h3B02_06E0;
    localparam logic [31:0] LOSS_DET_RST = 32'h1000_0000;
    localparam logic [4:0] READBACK_SEL_RST = 5'h00;

    // Masks of implemented bits; others read zero and ignore writes
    localparam logic [31:0] SYNC_MODE_MASK = 32'hFFFF_F020;
    localparam logic [31:0] LOCK_HOLD_MASK = 32'hFFC0_01C0;
    localparam logic [31:0] HOLD_REFSEL_MASK = 32'hFF77_FFE0;
    localparam logic [31:0] LOSS_DET_MASK = 32'hD000_0000;

    // Field positions
    localparam int SOFT_RESET_BIT = 17;
    localparam int SYNC_EXCL_LSB = 20;
    localparam int SYNC_OUT_SRC_LSB = 18;
    localparam int SYNC_OUTPUT_QUALIFY_BIT = 17;
    localparam int SYNC_POL_BIT = 16;
    localparam int SYNC_AUTO_BIT = 15;
    localparam int SYNC_ENABLE_BIT = 26;
    localparam int LOCK_SRC_LSB = 27;
    localparam int LOCK_KIND_LSB = 24;
    localparam int HOLD_LOOP2_BIT = 23;
    localparam int HOLD_LOOP1_BIT = 22;
    localparam int TRACK_BIT = 8;
    localparam int HOLD_MODE_LSB = 6;
    localparam int HOLD_PIN_KIND_LSB = 24;
    localparam int STAT1_SRC_LSB = 20;
    localparam int STAT0_KIND_LSB = 16;
    localparam int DROP_IGNORE_BIT = 15;
    localparam int STAT0_SRC_LSB = 12;
    localparam int REF_MODE_LSB = 9;
    localparam int STAT_INV_BIT = 8;
    localparam int REF_USABLE_LSB = 5;
    localparam int LOSS_TIME_LSB = 30;
    localparam int LOSS_ON_BIT = 28;
    localparam int READBACK_LSB = 16;

    // Holdover entry mode that enters holdover on loss of lock
    localparam logic [1:0] HOLD_ON_LOSS = 2'h2;

endpackage : sync_holdover_refin_pkg

//--- test/host_model.sv
// Host controller model that drives the serial programming pins of the bank.
// Assumes mclk at 50 MHz; each pin level is held six mclk cycles for the pin filter.
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input wire logic mclk,
    output logic spi_clk,
    output logic spi_data,
    output logic spi_latch,
    input wire logic spi_readout
);
    localparam int HOLD = 6; // Cycles per pin level, above the filter need

    // Idle pin levels before the first frame
    initial begin
        spi_clk = 1'b0;
        spi_data = 1'b1;
        spi_latch = 1'b0;
    end

    // Holds a level, then steps just past the clock edge
    task automatic hold_lvl();
        repeat (HOLD) @(posedge mclk);
        #1;
    endtask : hold_lvl

    // Latch pulse with clock low; takes the last 32 bits shifted
    task automatic pulse_latch();
        hold_lvl();
        spi_latch = 1'b1;
        hold_lvl();
        spi_latch = 1'b0;
        hold_lvl();
    endtask : pulse_latch

    // Shifts a frame MSB first, then latches it
    task automatic send_frame(input logic [31:0] frame);
        for (int i = 31; i >= 0; i--) begin
            spi_data = frame[i];
            hold_lvl();
            spi_clk = 1'b1;
            hold_lvl();
            spi_clk = 1'b0;
        end
        spi_data = ~frame[0]; // Released line shows no stale bit
        pulse_latch();
    endtask : send_frame

    // Collects readback: bit 31 first, one more bit after each clock rise
    task automatic read_out(output logic [31:0] v);
        v[31] = spi_readout;
        for (int i = 30; i >= 0; i--) begin
            spi_data = ~spi_data; // Data line toggles, nothing is latched
            hold_lvl();
            spi_clk = 1'b1;
            hold_lvl();
            v[i] = spi_readout;
            spi_clk = 1'b0;
        end
    endtask : read_out
endmodule : host_model
`default_nettype wire

//--- test/testbench.sv
// Self-checking bench for the sync, holdover and reference-input configuration bank.
// Assumes the host model drives the serial pins; lock inputs are driven on mclk.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic mclk, reset, loop1_lock, loop2_lock, sync_pin_in, spi_clk, spi_data, spi_latch;
    logic spi_readout, sync_output_qualify, sync_pin_polarity, sync_request, sync_auto_start;
    logic sync_hold, dac_track_on, holdover_enter, loop1_lock_drop_ignore, status_input_invert;
    logic signal_loss_detect_on;
    logic [5:0] sync_exclude;
    logic [4:0] lock_pin_source;
    logic [2:0] lock_pin_kind, holdover_pin_kind, status1_pin_source, status0_pin_kind;
    logic [2:0] status0_pin_source, reference_choice_mode, ref_input_usable;
    logic [1:0] sync_pin_out_source, holdover_mode, inactivity_loss_time;
    int err_count, checks_done, n_hold, n_auto, n0;
    logic [31:0] v;
    localparam logic [31:0] RST [4] = '{sync_holdover_refin_pkg::SYNC_MODE_RST,
        sync_holdover_refin_pkg::LOCK_HOLD_RST, sync_holdover_refin_pkg::HOLD_REFSEL_RST,
        sync_holdover_refin_pkg::LOSS_DET_RST};
    localparam logic [31:0] MSK [4] = '{sync_holdover_refin_pkg::SYNC_MODE_MASK,
        sync_holdover_refin_pkg::LOCK_HOLD_MASK, sync_holdover_refin_pkg::HOLD_REFSEL_MASK,
        sync_holdover_refin_pkg::LOSS_DET_MASK};

    sync_holdover_refin_config i_dut (.mclk, .reset, .spi_clk, .spi_data, .spi_latch,
        .spi_readout, .loop1_lock, .loop2_lock, .sync_pin_in, .sync_exclude,
        .sync_pin_out_source, .sync_output_qualify, .sync_pin_polarity, .sync_request,
        .sync_auto_start, .sync_hold, .lock_pin_source, .lock_pin_kind, .dac_track_on,
        .holdover_mode, .holdover_enter, .holdover_pin_kind, .status1_pin_source,
        .status0_pin_kind, .status0_pin_source, .loop1_lock_drop_ignore,
        .reference_choice_mode, .status_input_invert, .ref_input_usable,
        .inactivity_loss_time, .signal_loss_detect_on);
    host_model i_host (.mclk, .spi_clk, .spi_data, .spi_latch, .spi_readout);

    // 50 MHz clock
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // Counts the one-cycle event pulses
    always @(posedge mclk) begin
        if (holdover_enter === 1'b1) n_hold++;
        if (sync_auto_start === 1'b1) n_auto++;
    end

    // Compares one value and records a mismatch
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Register write and readback through the serial pins
    task automatic wr(input logic [4:0] a, input logic [31:0] val);
        i_host.send_frame({val[31:5], a});
    endtask : wr
    task automatic rd(input logic [4:0] a, output logic [31:0] val);
        i_host.send_frame({11'h0, a, 11'h0, 5'h1F});
        i_host.pulse_latch();
        i_host.read_out(val);
    endtask : rd

    // Checks every field output against expected register images
    task automatic chk_fields(input logic [31:0] b, c, d, e);
        chk({22'h0, sync_exclude, sync_pin_out_source, sync_output_qualify,
            sync_pin_polarity}, {22'h0, b[25:16]});
        chk({24'h0, lock_pin_source, lock_pin_kind}, {24'h0, c[31:24]});
        chk({29'h0, dac_track_on, holdover_mode}, {29'h0, c[8:6]});
        chk({10'h0, holdover_pin_kind, 1'b0, status1_pin_source, 1'b0, status0_pin_kind,
            loop1_lock_drop_ignore, status0_pin_source, reference_choice_mode,
            status_input_invert, ref_input_usable}, {10'h0, d[26:5]});
        chk({28'h0, inactivity_loss_time, 1'b0, signal_loss_detect_on},
            {28'h0, e[31:28]});
    endtask : chk_fields

    // Drives both lock levels, then lets them settle
    task automatic drv_lock(input logic l1, input logic l2);
        loop1_lock = l1;
        loop2_lock = l2;
        repeat (3) @(posedge mclk);
        #1;
    endtask : drv_lock

    // Prints the counts and the verdict, then stops
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict

    // Watchdog against a hung run
    initial begin
        repeat (40000) @(posedge mclk);
        err_count++;
        print_verdict();
    end

    // Test sequence
    initial begin
        {reset, loop1_lock, loop2_lock, sync_pin_in} = 4'hF;
        {err_count, checks_done, n_hold, n_auto} = '0;
        repeat (2) @(posedge mclk);
        #1 reset = 1'b0;
        repeat (4) @(posedge mclk);
        #1 chk_fields(RST[0], RST[1], RST[2], RST[3]);
        for (int a = 0; a < 4; a++) begin
            rd(5'(11 + a), v);
            chk(v, RST[a]);
        end
        for (int a = 0; a < 4; a++) begin
            wr(5'(11 + a), 32'hFFFF_FFFF);
            rd(5'(11 + a), v);
            chk(v, MSK[a]);
        end
        chk_fields(MSK[0], MSK[1], MSK[2], MSK[3]);
        for (int a = 0; a < 4; a++) wr(5'(11 + a), 32'h0);
        chk_fields(32'h0, 32'h0, 32'h0, 32'h0);
        wr(5'h00, 32'h0002_0000);
        chk_fields(RST[0], RST[1], RST[2], RST[3]);
        wr(5'h0C, RST[1] | 32'h00C0_0000);
        drv_lock(1'b1, 1'b0);
        chk({31'h0, sync_hold}, 32'h1);
        n0 = n_hold;
        drv_lock(1'b0, 1'b1);
        chk({31'h0, sync_hold}, 32'h1);
        chk(32'(n_hold - n0), 32'h1);
        drv_lock(1'b1, 1'b1);
        chk({31'h0, sync_hold}, 32'h0);
        wr(5'h0D, RST[2] | 32'h0000_8000);
        n0 = n_hold;
        drv_lock(1'b0, 1'b1);
        drv_lock(1'b1, 1'b1);
        chk(32'(n_hold - n0), 32'h0);
        // Entry mode other than two: a lock drop must not enter holdover
        wr(5'h0D, RST[2]);
        wr(5'h0C, RST[1] & ~32'h0000_00C0);
        n0 = n_hold;
        drv_lock(1'b0, 1'b1);
        drv_lock(1'b1, 1'b1);
        chk(32'(n_hold - n0), 32'h0);
        n0 = n_auto;
        wr(5'h02, 32'h0);
        chk(32'(n_auto - n0), 32'h0);
        wr(5'h0B, RST[0] | 32'h0000_8000);
        wr(5'h03, 32'h0);
        chk(32'(n_auto - n0), 32'h1);
        sync_pin_in = 1'b0;
        repeat (8) @(posedge mclk);
        #1 chk({31'h0, sync_request}, 32'h1);
        sync_pin_in = 1'b1;
        repeat (8) @(posedge mclk);
        #1 chk({31'h0, sync_request}, 32'h0);
        // Polarity zero makes the idle-high pin active
        wr(5'h0B, RST[0] & ~32'h0001_0000);
        chk({31'h0, sync_request}, 32'h1);
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
